// File: src/uxf_efr.sv
// What this block does
// - feature reg at 0x02, reset zero, reachable only when format reg is 0xBF, lock clear
// - bit 7 turns automatic clear-to-send transmit gating on or off
// - bit 6 turns automatic request-to-send receive gating on or off
// - bit 5 matches second stop char: store it and flag special character
// - if flow also compares it: drop it, raise special interrupt and stop (in 1111/0011 stop only after first stop char)
// - enhanced register fields writable only while bit 4 set
// - bits 3:2 select which resume/stop pairs are transmitted
// - bits 1:0 select which resume/stop pairs the receiver compares
// - 1011 and 0111 send one pair, receiver accepts either char of each kind
// - 1111 and 0011 require both chars as two-character sequences
// - stop-caused flag clears on resume; special-caused flag clears on id read
// - that interrupt reports code 010000 at priority 6
`timescale 1ns/1ps
`default_nettype none
module uxf_feat_ctrl (
    input  wire logic                        clk,           // 20 MHz
    input  wire logic                        rst_b,         // async reset
    input  wire logic [3:0]                  reg_addr,      // register offset
    input  wire logic                        reg_wr,        // write strobe
    input  wire logic                        reg_rd,        // read strobe
    input  wire logic [7:0]                  reg_wdata,     // write data
    output logic      [7:0]                  reg_rdata,     // read data
    input  wire logic                        spec_fn_lock,  // special function bit 2
    input  wire logic                        int_id_rd,     // id register read
    input  wire uxf_pkg::uxf_flow_chars_type flow_chars,    // resume/stop chars
    input  wire logic                        cts_active,    // partner ready
    input  wire logic                        rx_halt,       // rx fifo above halt level
    input  wire logic                        modem_ctrl_rts,// manual rts level
    output logic                             rts_active,    // rts to partner
    input  wire logic                        tx_start_req,  // transmitter wants a char
    output logic                             tx_start_ok,   // char may start
    input  wire logic                        sleep_req,     // sleep request
    output logic                             sleep_en,      // sleep allowed
    output logic                             enh_wr_en,     // enhanced fields writable
    input  wire logic                        rx_valid,      // received char strobe
    input  wire logic [7:0]                  rx_char,       // received char
    output logic                             rx_push,       // push to rx fifo
    output logic      [7:0]                  rx_push_data,  // char to rx fifo
    output logic                             xoff_held,     // tx stopped by stop char
    output logic                             tx_send_first, // send first pair
    output logic                             tx_send_second,// send second pair
    output logic                             tx_send_double,// pairs as sequences
    output logic                             int_pend,      // stop/special interrupt
    output logic      [5:0]                  int_code,      // id register code
    output logic      [2:0]                  int_prio       // priority level
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] feat_r, feat_nxt, fmt_r, fmt_nxt, rdata_r, rdata_nxt;
    logic       unlocked;

    assign unlocked = (fmt_r == uxf_pkg::UXF_FMT_UNLOCK) && !spec_fn_lock;

    always_comb begin
        feat_nxt  = feat_r;
        fmt_nxt   = fmt_r;
        rdata_nxt = rdata_r;
        if (reg_wr && reg_addr == uxf_pkg::UXF_FEAT_OFS && unlocked) begin
            feat_nxt = reg_wdata;
        end
        if (reg_wr && reg_addr == uxf_pkg::UXF_FMT_OFS) begin
            fmt_nxt = reg_wdata;
        end
        if (reg_rd) begin
            if (reg_addr == uxf_pkg::UXF_FEAT_OFS && unlocked) begin
                rdata_nxt = feat_r;
            end else if (reg_addr == uxf_pkg::UXF_FMT_OFS) begin
                rdata_nxt = fmt_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            feat_r  <= uxf_pkg::UXF_FEAT_RST;
            fmt_r   <= uxf_pkg::UXF_FMT_RST;
            rdata_r <= 8'h00;
        end else begin
            feat_r  <= feat_nxt;
            fmt_r   <= fmt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] tx_sel, rx_sel;
    logic       cts_en, rts_en, spec_en, enh_en, xoff_held_r;

    assign cts_en  = feat_r[uxf_pkg::UXF_FEAT_CTS];
    assign rts_en  = feat_r[uxf_pkg::UXF_FEAT_RTS];
    assign spec_en = feat_r[uxf_pkg::UXF_FEAT_SPEC];
    assign enh_en  = feat_r[uxf_pkg::UXF_FEAT_ENH];
    assign tx_sel  = feat_r[uxf_pkg::UXF_FEAT_TX_LO +: 2];
    assign rx_sel  = feat_r[1:0];

    // only gates the start, a char already shifting is finished
    assign tx_start_ok    = tx_start_req && (!cts_en || cts_active)
                            && !xoff_held_r;
    assign rts_active     = rts_en ? !rx_halt : modem_ctrl_rts;
    assign enh_wr_en      = enh_en;
    assign sleep_en       = sleep_req && enh_en;
    assign tx_send_first  = tx_sel[1];
    assign tx_send_second = tx_sel[0];
    assign tx_send_double = (tx_sel == uxf_pkg::UXF_SW_BOTH);

    ////////////////////////////////////////////////////////////////////////////
    uxf_pkg::uxf_seq_type seq_r, seq_nxt;
    logic m_on1, m_on2, m_off1, m_off2, either, dbl;
    logic xon_ev, xoff_ev, spec_ev, swallow;
    logic push_r, push_nxt, held_nxt;
    logic [7:0] pdata_r, pdata_nxt;

    assign m_on1  = rx_char == flow_chars.first_resume_char;
    assign m_on2  = rx_char == flow_chars.second_resume_char;
    assign m_off1 = rx_char == flow_chars.first_stop_char;
    assign m_off2 = rx_char == flow_chars.second_stop_char;
    assign either = (rx_sel == uxf_pkg::UXF_SW_BOTH) &&
                    (tx_sel == uxf_pkg::UXF_SW_FIRST || tx_sel == uxf_pkg::UXF_SW_SECOND);
    assign dbl    = (rx_sel == uxf_pkg::UXF_SW_BOTH) && !either;

    always_comb begin
        seq_nxt = seq_r;
        xon_ev  = 1'b0;
        xoff_ev = 1'b0;
        swallow = 1'b0;
        spec_ev = rx_valid && spec_en && m_off2;
        if (!dbl) begin
            seq_nxt = uxf_pkg::UXF_SEQ_IDLE;
        end
        if (rx_valid) begin
            unique case (rx_sel)
                uxf_pkg::UXF_SW_FIRST: begin
                    xon_ev  = m_on1;
                    xoff_ev = m_off1;
                end
                uxf_pkg::UXF_SW_SECOND: begin
                    xon_ev  = m_on2;
                    xoff_ev = m_off2;
                end
                uxf_pkg::UXF_SW_BOTH: begin
                    if (either) begin
                        xon_ev  = m_on1 || m_on2;
                        xoff_ev = m_off1 || m_off2;
                    end else begin
                        unique case (seq_r)
                            uxf_pkg::UXF_SEQ_ON1: begin
                                xon_ev  = m_on2;
                                swallow = m_on2;
                                seq_nxt = uxf_pkg::UXF_SEQ_IDLE;
                            end
                            uxf_pkg::UXF_SEQ_OFF1: begin
                                xoff_ev = m_off2;
                                swallow = m_off2;
                                seq_nxt = uxf_pkg::UXF_SEQ_IDLE;
                            end
                            default: begin
                                swallow = m_on1 || m_off1;
                                if (m_on1) begin
                                    seq_nxt = uxf_pkg::UXF_SEQ_ON1;
                                end else if (m_off1) begin
                                    seq_nxt = uxf_pkg::UXF_SEQ_OFF1;
                                end
                            end
                        endcase
                    end
                end
                uxf_pkg::UXF_SW_NONE: begin
                end
            endcase
            swallow = swallow || xon_ev || xoff_ev;
            if (spec_ev && rx_sel[0]) begin
                swallow = 1'b1;
            end
        end
    end

    always_comb begin
        push_nxt  = rx_valid && !swallow;
        pdata_nxt = rx_valid ? rx_char : pdata_r;
        held_nxt  = xoff_held_r;
        if (xon_ev) begin
            held_nxt = 1'b0;
        end
        if (xoff_ev) begin
            held_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_r       <= uxf_pkg::UXF_SEQ_IDLE;
            push_r      <= 1'b0;
            pdata_r     <= 8'h00;
            xoff_held_r <= 1'b0;
        end else begin
            seq_r       <= seq_nxt;
            push_r      <= push_nxt;
            pdata_r     <= pdata_nxt;
            xoff_held_r <= held_nxt;
        end
    end

    assign rx_push      = push_r;
    assign rx_push_data = pdata_r;
    assign xoff_held    = xoff_held_r;

    ////////////////////////////////////////////////////////////////////////////
    logic int_r, int_nxt, cause_r, cause_nxt;

    always_comb begin
        int_nxt   = int_r;
        cause_nxt = cause_r;
        if ((xon_ev && !cause_r) || (int_id_rd && cause_r)) begin
            int_nxt = 1'b0;
        end
        if (xoff_ev || spec_ev) begin
            int_nxt   = 1'b1;
            cause_nxt = spec_ev;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_r   <= 1'b0;
            cause_r <= 1'b0;
        end else begin
            int_r   <= int_nxt;
            cause_r <= cause_nxt;
        end
    end

    assign int_pend = int_r;
    assign int_code = int_r ? uxf_pkg::UXF_INT_XOFF : uxf_pkg::UXF_INT_NONE;
    assign int_prio = uxf_pkg::UXF_INT_PRIO;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_spec_in;
        rx_valid && spec_en && m_off2 && !dbl;
    endsequence

    property p_feat_lock;
        reg_wr && reg_addr == uxf_pkg::UXF_FEAT_OFS && !unlocked |=> $stable(feat_r);
    endproperty
    a_feat_lock: assert property (p_feat_lock) else $error("locked reg written");

    property p_feat_wr;
        reg_wr && reg_addr == uxf_pkg::UXF_FEAT_OFS && unlocked |=> feat_r == $past(reg_wdata);
    endproperty
    a_feat_wr: assert property (p_feat_wr) else $error("feature reg write lost");

    property p_cts;
        cts_en && !cts_active |-> !tx_start_ok;
    endproperty
    a_cts: assert property (p_cts) else $error("char started while cts inactive");

    property p_rts;
        rts_en |-> rts_active == !rx_halt;
    endproperty
    a_rts: assert property (p_rts) else $error("rts not following halt level");

    property p_spec_store;
        s_spec_in and (!rx_sel[0]) |=> rx_push && rx_push_data == $past(rx_char) && int_pend;
    endproperty
    a_spec_store: assert property (p_spec_store) else $error("special not stored");

    property p_spec_flow;
        s_spec_in and (rx_sel == uxf_pkg::UXF_SW_SECOND) |=> !rx_push && int_pend && xoff_held;
    endproperty
    a_spec_flow: assert property (p_spec_flow) else $error("special stop wrong");

    property p_enh;
        reg_wr && reg_addr == uxf_pkg::UXF_FEAT_OFS && unlocked
            |=> enh_wr_en == $past(reg_wdata[uxf_pkg::UXF_FEAT_ENH]);
    endproperty
    a_enh: assert property (p_enh) else $error("enhanced gate wrong");

    property p_sleep;
        sleep_req && !enh_en |-> !sleep_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep allowed without enable");

    property p_either;
        either && rx_valid && m_off2 && !m_on1 && !m_on2 |=> xoff_held;
    endproperty
    a_either: assert property (p_either) else $error("either-char stop missed");

    property p_int_clr;
        int_pend && cause_r && int_id_rd && !xoff_ev && !spec_ev |=> !int_pend;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("special flag kept");

    property p_code;
        int_pend |-> int_code == 6'h10 && int_prio == 3'h6;
    endproperty
    a_code: assert property (p_code) else $error("wrong interrupt code");

endmodule : uxf_feat_ctrl
`default_nettype wire

// File: src/uxf_pkg.sv
package uxf_pkg;
    localparam logic [3:0] UXF_FEAT_OFS   = 4'h2;
    localparam logic [3:0] UXF_FMT_OFS    = 4'h3;
    localparam logic [7:0] UXF_FEAT_RST   = 8'h00;
    localparam logic [7:0] UXF_FMT_RST    = 8'h1D;
    localparam logic [7:0] UXF_FMT_UNLOCK = 8'hBF;
    localparam int         UXF_FEAT_CTS   = 7;
    localparam int         UXF_FEAT_RTS   = 6;
    localparam int         UXF_FEAT_SPEC  = 5;
    localparam int         UXF_FEAT_ENH   = 4;
    localparam int         UXF_FEAT_TX_LO = 2;
    localparam logic [1:0] UXF_SW_NONE    = 2'h0;
    localparam logic [1:0] UXF_SW_FIRST   = 2'h2;
    localparam logic [1:0] UXF_SW_SECOND  = 2'h1;
    localparam logic [1:0] UXF_SW_BOTH    = 2'h3;
    localparam logic [5:0] UXF_INT_XOFF   = 6'h10;
    localparam logic [5:0] UXF_INT_NONE   = 6'h01;
    localparam logic [2:0] UXF_INT_PRIO   = 3'h6;

    typedef struct packed {
        logic [7:0] first_resume_char;
        logic [7:0] second_resume_char;
        logic [7:0] first_stop_char;
        logic [7:0] second_stop_char;
    } uxf_flow_chars_type;

    typedef enum logic [1:0] {
        UXF_SEQ_IDLE,
        UXF_SEQ_ON1,
        UXF_SEQ_OFF1
    } uxf_seq_type;
endpackage : uxf_pkg

// File: test/test_uart_enhanced_flow_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_uart_enhanced_flow_control;
    logic clk, rst_b, reg_wr, reg_rd, spec_fn_lock, int_id_rd, rx_halt, modem_ctrl_rts;
    logic tx_start_req, sleep_req, rx_valid, cts_active, rts_active;
    logic tx_start_ok, sleep_en, enh_wr_en, rx_push, xoff_held, int_pend;
    logic tx_send_first, tx_send_second, tx_send_double;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rx_char, rx_push_data;
    logic [5:0] int_code;
    logic [2:0] int_prio;
    uxf_pkg::uxf_flow_chars_type flow_chars;
    int   mismatches = 0;
    int   n_checks   = 0;

    uxf_feat_ctrl uxf_feat_ctrl_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .spec_fn_lock(spec_fn_lock), .int_id_rd(int_id_rd), .flow_chars(flow_chars),
        .cts_active(cts_active), .rx_halt(rx_halt), .modem_ctrl_rts(modem_ctrl_rts),
        .rts_active(rts_active), .tx_start_req(tx_start_req),
        .tx_start_ok(tx_start_ok), .sleep_req(sleep_req), .sleep_en(sleep_en),
        .enh_wr_en(enh_wr_en), .rx_valid(rx_valid), .rx_char(rx_char), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .xoff_held(xoff_held), .tx_send_first(tx_send_first),
        .tx_send_second(tx_send_second), .tx_send_double(tx_send_double),
        .int_pend(int_pend), .int_code(int_code), .int_prio(int_prio));
    uxf_remote uxf_remote_i (.clk(clk), .rts_active(rts_active), .rx_valid(rx_valid),
        .rx_char(rx_char), .cts_active(cts_active));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0; reg_wdata = ~d;
    endtask : wr

    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(what, exp, reg_rdata);
    endtask : rd

    task automatic id_read;
        @(negedge clk);
        int_id_rd = 1'b1;
        @(negedge clk);
        int_id_rd = 1'b0;
    endtask : id_read

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        wr(4'h2, 8'hD0);
        rd("feature locked", 4'h2, 8'h00);
        rd("format reset", 4'h3, 8'h1D);
        rd("unmapped", 4'h9, 8'h00);
        wr(4'h3, uxf_pkg::UXF_FMT_UNLOCK);
        rd("feature reset", 4'h2, 8'h00);
        wr(4'h2, 8'hD0);
        rd("feature rw", 4'h2, 8'hD0);
        spec_fn_lock = 1'b1;
        rd("feature lock bit", 4'h2, 8'h00);
        spec_fn_lock = 1'b0;
        chk("enh_wr_en", 8'h01, {7'h0, enh_wr_en});
        sleep_req = 1'b1;
        #1 chk("sleep_en", 8'h01, {7'h0, sleep_en});
        $display("t_regs done");
    endtask : t_regs

    task automatic t_hw_flow;
        rx_halt = 1'b1;
        #1 chk("rts auto halt", 8'h00, {7'h0, rts_active});
        rx_halt = 1'b0;
        #1 chk("rts auto go", 8'h01, {7'h0, rts_active});
        uxf_remote_i.set_ready(1'b0);
        #1 chk("tx gated", 8'h00, {7'h0, tx_start_ok});
        uxf_remote_i.set_ready(1'b1);
        #1 chk("tx resumed", 8'h01, {7'h0, tx_start_ok});
        wr(4'h2, 8'h10);
        uxf_remote_i.set_ready(1'b0);
        rx_halt = 1'b1;
        #1 chk("tx ungated", 8'h01, {7'h0, tx_start_ok});
        chk("rts manual", 8'h01, {7'h0, rts_active});
        @(negedge clk);
        modem_ctrl_rts = 1'b0;
        tx_start_req = 1'b0;
        #1 chk("rts manual low", 8'h00, {7'h0, rts_active});
        chk("tx no request", 8'h00, {7'h0, tx_start_ok});
        @(negedge clk);
        modem_ctrl_rts = 1'b1;
        tx_start_req = 1'b1;
        sleep_req = 1'b1;
        chk("enh_wr_en on", 8'h01, {7'h0, enh_wr_en});
        wr(4'h2, 8'h00);
        chk("enh_wr_en off", 8'h00, {7'h0, enh_wr_en});
        chk("sleep refused", 8'h00, {7'h0, sleep_en});
        uxf_remote_i.set_ready(1'b1);
        rx_halt = 1'b0;
        $display("t_hw_flow done");
    endtask : t_hw_flow

    task automatic t_tx_select;
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, {4'h1, i[1:0], 2'b00});
            chk("tx sel", {5'h0, i[1], i[0], &i[1:0]},
                {5'h0, tx_send_first, tx_send_second, tx_send_double});
        end
        $display("t_tx_select done");
    endtask : t_tx_select

    task automatic t_rx_first;
        wr(4'h2, 8'h12);
        uxf_remote_i.send_char(8'h41, 0);
        chk("plain push", 8'h41, rx_push ? rx_push_data : 8'h00);
        uxf_remote_i.send_char(8'h13, 1);
        chk("stop swallowed", 8'h00, {7'h0, rx_push});
        chk("stop held", 8'h01, {7'h0, xoff_held});
        chk("int code", {2'h0, uxf_pkg::UXF_INT_XOFF}, {2'h0, int_code});
        chk("int prio", 8'h06, {5'h0, int_prio});
        #1 chk("tx blocked", 8'h00, {7'h0, tx_start_ok});
        uxf_remote_i.send_char(8'h12, 0);
        chk("other pair ignored", 8'h01, {7'h0, xoff_held});
        uxf_remote_i.send_char(8'h11, 0);
        chk("resume", 8'h00, {7'h0, xoff_held});
        chk("int cleared", 8'h00, {7'h0, int_pend});
        chk("int none", 8'h01, {2'h0, int_code});
        $display("t_rx_first done");
    endtask : t_rx_first

    task automatic t_special;
        wr(4'h2, 8'h30);
        uxf_remote_i.send_char(8'h14, 0);
        chk("special push", 8'h14, rx_push ? rx_push_data : 8'h00);
        chk("special int", 8'h01, {7'h0, int_pend});
        id_read;
        chk("special clear", 8'h00, {7'h0, int_pend});
        wr(4'h2, 8'h31);
        uxf_remote_i.send_char(8'h14, 0);
        chk("both no push", 8'h00, {7'h0, rx_push});
        chk("both held", 8'h01, {7'h0, xoff_held});
        chk("both int", 8'h01, {7'h0, int_pend});
        uxf_remote_i.send_char(8'h12, 2);
        chk("both resume", 8'h00, {7'h0, xoff_held});
        id_read;
        chk("both clear", 8'h00, {7'h0, int_pend});
        $display("t_special done");
    endtask : t_special

    task automatic t_pairs;
        wr(4'h2, 8'h0F);
        uxf_remote_i.send_char(8'h13, 0);
        chk("dbl first", 8'h00, {7'h0, rx_push | xoff_held});
        uxf_remote_i.send_char(8'h14, 0);
        chk("dbl stop", 8'h01, {7'h0, xoff_held});
        uxf_remote_i.send_char(8'h11, 0);
        chk("dbl half", 8'h01, {7'h0, xoff_held});
        uxf_remote_i.send_char(8'h12, 0);
        chk("dbl resume", 8'h00, {7'h0, xoff_held});
        wr(4'h2, 8'h1B);
        chk("either tx", 8'h02, {6'h0, tx_send_first, tx_send_second});
        uxf_remote_i.send_char(8'h14, 0);
        chk("either stop", 8'h01, {7'h0, xoff_held});
        uxf_remote_i.send_char(8'h11, 0);
        chk("either resume", 8'h00, {7'h0, xoff_held});
        id_read;
        $display("t_pairs done");
    endtask : t_pairs

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
        spec_fn_lock = 1'b0; int_id_rd = 1'b0; rx_halt = 1'b0; modem_ctrl_rts = 1'b1;
        tx_start_req = 1'b1; sleep_req = 1'b0;
        flow_chars = {8'h11, 8'h12, 8'h13, 8'h14};
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_regs;
        t_hw_flow;
        t_tx_select;
        t_rx_first;
        t_special;
        t_pairs;
        report_and_stop;
    end

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        report_and_stop;
    end
endmodule : test_uart_enhanced_flow_control
`default_nettype wire

// File: test/uxf_remote.sv
`timescale 1ns/1ps
`default_nettype none
module uxf_remote (
    input  wire logic       clk,        // device clock
    input  wire logic       rts_active, // device ready for data
    output logic            rx_valid,   // char strobe into device
    output logic      [7:0] rx_char,    // char into device
    output logic            cts_active  // remote ready
);
    initial begin
        rx_valid   = 1'b0;
        rx_char    = 8'hA5;
        cts_active = 1'b1;
    end

    // one char per call, held back while device rts is inactive; line shows inverse after release
    task automatic send_char(input logic [7:0] c, input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        while (!rts_active) @(negedge clk);
        rx_valid = 1'b1;
        rx_char  = c;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_char  = ~c;
    endtask : send_char

    task automatic set_ready(input logic v);
        @(negedge clk);
        cts_active = v;
    endtask : set_ready
endmodule : uxf_remote
`default_nettype wire
